// File: logic/rtcs_top.sv
// rtc time count mode, stop control and clock output with ahb-lite registers
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module rtcs_top import rtcs_pkg::*; (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_IN,
	// ahb-lite slave
	input wire logic HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic [31:0] HRDATA_OUT,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT,
	// pins
	input wire logic EVENT_PIN_IN,
	input wire logic ON_BATTERY_IN,
	output logic CLKOUT_OUT,
	output logic EVENT_PIN_OUT,
	output logic EVENT_PIN_OE_N_OUT,
	output logic IRQ_A_PIN_OUT,
	output logic IRQ_A_PIN_OE_N_OUT,
	// time counter control
	output logic COUNT_RUN_OUT,
	output logic TIME_COUNT_MODE_OUT,
	output logic HUNDREDTH_TICK_OUT,
	output logic SECOND_TICK_OUT
);
	////////////////////////////////////////////////////////////////////////////////
	// oscillator and prescaler
	logic osc;
	logic osc_rise;
	logic [DIV_W-1:0] div;
	logic hund_tick;
	logic sec_tick;

	rtcs_osc_div #(.W(DIV_W)) u_div (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.osc_out(osc),
		.osc_rise_out(osc_rise),
		.div_out(div),
		.hund_tick_out(hund_tick),
		.sec_tick_out(sec_tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [1:0] evt_sync_reg, evt_sync_next;
	logic [1:0] bat_sync_reg, bat_sync_next;
	logic evt_pin;
	logic on_bat;

	always_comb begin
		evt_sync_next = {evt_sync_reg[0], EVENT_PIN_IN};
		bat_sync_next = {bat_sync_reg[0], ON_BATTERY_IN};
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			evt_sync_reg <= 2'h0;
			bat_sync_reg <= 2'h0;
		end else begin
			evt_sync_reg <= evt_sync_next;
			bat_sync_reg <= bat_sync_next;
		end
	end

	assign evt_pin = evt_sync_reg[1];
	assign on_bat = bat_sync_reg[1];

	////////////////////////////////////////////////////////////////////////////////
	// ahb-lite register slave
	rtcs_func_t func_reg, func_next;
	rtcs_ctrl_t ctrl_reg, ctrl_next;
	logic wr_pend_reg, wr_pend_next;
	logic [ADDR_W-1:0] wr_addr_reg, wr_addr_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [7:0] stat;
	logic take;

	always_comb begin
		take = HSEL_IN & HREADY_IN & HTRANS_IN[1];
		func_next = func_reg;
		ctrl_next = ctrl_reg;
		if (wr_pend_reg && wr_addr_reg == FUNC_ADDR) begin
			func_next = rtcs_func_t'(HWDATA_IN[7:0]);
		end
		if (wr_pend_reg && wr_addr_reg == CTRL_ADDR) begin
			ctrl_next = rtcs_ctrl_t'(HWDATA_IN[7:0]);
		end
		wr_pend_next = take & HWRITE_IN;
		wr_addr_next = HADDR_IN[ADDR_W-1:0];
		rdata_next = 32'h0000_0000;
		// read data reflects a write finishing in the same cycle
		if (take && !HWRITE_IN) begin
			case (HADDR_IN[ADDR_W-1:0])
				FUNC_ADDR: rdata_next = {24'h00_0000, func_next};
				CTRL_ADDR: rdata_next = {24'h00_0000, ctrl_next};
				STAT_ADDR: rdata_next = {24'h00_0000, stat};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			func_reg <= rtcs_func_t'(FUNC_RST);
			ctrl_reg <= rtcs_ctrl_t'(CTRL_RST);
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			func_reg <= func_next;
			ctrl_reg <= ctrl_next;
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			rdata_reg <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// stop control and counter ticks
	logic pin_stop;
	logic run;
	logic run_reg, run_next;
	logic mode_reg, mode_next;
	logic hund_out_reg, hund_out_next;
	logic sec_out_reg, sec_out_next;

	always_comb begin
		// polarity 0: high stops; polarity 1: low stops
		pin_stop = func_reg.stop_source_sel & (ctrl_reg.event_pin_mode == EVT_MODE_INPUT)
			& (evt_pin ^ ctrl_reg.event_pin_polarity);
		run = ~ctrl_reg.stop & ~pin_stop;
		run_next = run;
		mode_next = func_reg.time_count_mode_sel;
		hund_out_next = hund_tick & run & func_reg.hundredths_enable;
		sec_out_next = sec_tick & run;
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			run_reg <= 1'b1;
			mode_reg <= 1'b0;
			hund_out_reg <= 1'b0;
			sec_out_reg <= 1'b0;
		end else begin
			run_reg <= run_next;
			mode_reg <= mode_next;
			hund_out_reg <= hund_out_next;
			sec_out_reg <= sec_out_next;
		end
	end

	assign stat = {3'h0, osc, on_bat, evt_pin, pin_stop, run_reg};

	////////////////////////////////////////////////////////////////////////////////
	// clock output selection and pins
	logic sel_clk;
	logic clk_lvl;
	logic clk_off;
	logic clk_pin_reg, clk_pin_next;
	logic evt_out_reg, evt_out_next;
	logic evt_oe_n_reg, evt_oe_n_next;
	logic irq_oe_n_reg, irq_oe_n_next;
	logic irq_out_reg;

	always_comb begin
		clk_off = func_reg.clkout_freq_sel == FREQ_SEL_OFF;
		case (func_reg.clkout_freq_sel)
			FREQ_SEL_OSC: sel_clk = osc;
			FREQ_SEL_1HZ: sel_clk = div[DIV_1HZ_BIT];
			FREQ_SEL_OFF: sel_clk = 1'b0;
			default: sel_clk = div[func_reg.clkout_freq_sel - 3'h1];
		endcase
		clk_lvl = clk_off ? 1'b0 : (sel_clk ^ ctrl_reg.clkout_invert);
		clk_pin_next = clk_lvl & ~ctrl_reg.clkout_pin_disable;
		evt_out_next = clk_lvl;
		evt_oe_n_next = ctrl_reg.event_pin_mode != EVT_MODE_CLK;
		irq_oe_n_next = 1'b1;
		case (ctrl_reg.irq_a_pin_mode)
			// open drain, pulled low in the clock's low phase, released on battery
			IRQ_MODE_CLK: irq_oe_n_next = clk_off | on_bat | clk_lvl;
			IRQ_MODE_BAT: irq_oe_n_next = ~on_bat;
			default: irq_oe_n_next = 1'b1;
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			clk_pin_reg <= 1'b0;
			evt_out_reg <= 1'b0;
			evt_oe_n_reg <= 1'b1;
			irq_oe_n_reg <= 1'b1;
			irq_out_reg <= 1'b0;
		end else begin
			clk_pin_reg <= clk_pin_next;
			evt_out_reg <= evt_out_next;
			evt_oe_n_reg <= evt_oe_n_next;
			irq_oe_n_reg <= irq_oe_n_next;
			irq_out_reg <= 1'b0;
		end
	end

	assign HRDATA_OUT = rdata_reg;
	assign HREADYOUT_OUT = 1'b1;
	assign HRESP_OUT = 1'b0;
	assign CLKOUT_OUT = clk_pin_reg;
	assign EVENT_PIN_OUT = evt_out_reg;
	assign EVENT_PIN_OE_N_OUT = evt_oe_n_reg;
	assign IRQ_A_PIN_OUT = irq_out_reg;
	assign IRQ_A_PIN_OE_N_OUT = irq_oe_n_reg;
	assign COUNT_RUN_OUT = run_reg;
	assign TIME_COUNT_MODE_OUT = mode_reg;
	assign HUNDREDTH_TICK_OUT = hund_out_reg;
	assign SECOND_TICK_OUT = sec_out_reg;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	a_soft_stop_halts: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		ctrl_reg.stop |=> !run_reg && !sec_out_reg)
		else $error("software stop did not halt counting");
	a_src0_pin_ignored: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		!func_reg.stop_source_sel && !ctrl_reg.stop |=> run_reg)
		else $error("pin stopped counting with source select 0");
	a_pin_polarity_stop: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		func_reg.stop_source_sel && ctrl_reg.event_pin_mode == EVT_MODE_INPUT
		&& !ctrl_reg.stop |=> run_reg == ($past(evt_sync_reg[1]) == $past(ctrl_reg.event_pin_polarity)))
		else $error("pin stop polarity wrong");
	a_run_resumes: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		$fell(ctrl_reg.stop) && !pin_stop |=> run_reg)
		else $error("counting did not resume");
	a_hund_gated: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		HUNDREDTH_TICK_OUT |-> $past(func_reg.hundredths_enable) && $past(run))
		else $error("hundredth tick while disabled");
	a_clk_disabled_low: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		ctrl_reg.clkout_pin_disable [*2] |-> !CLKOUT_OUT)
		else $error("disabled clock pin not low");
	a_clk_off_static: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		func_reg.clkout_freq_sel == FREQ_SEL_OFF [*2] |-> !CLKOUT_OUT && !EVENT_PIN_OUT)
		else $error("clock off code not static low");
	a_clk_reset_osc: assert property (@(posedge CLK_IN)
		$fell(RST_IN) |-> func_reg.clkout_freq_sel == FREQ_SEL_OSC)
		else $error("frequency field not at oscillator rate after reset");
	a_irq_batt_hiz: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		on_bat && ctrl_reg.irq_a_pin_mode == IRQ_MODE_CLK |=> IRQ_A_PIN_OE_N_OUT)
		else $error("irq clock driven on battery");
	a_clk_follows_div: assert property (@(posedge CLK_IN) disable iff (RST_IN)
		func_reg.clkout_freq_sel == 3'h1 && !ctrl_reg.clkout_invert
		&& !ctrl_reg.clkout_pin_disable |=> CLKOUT_OUT == $past(div[0]))
		else $error("16384 hz output not from first divider stage");
endmodule // rtcs_top

// File: inc/rtcs_pkg.sv
// constants, register map and field layouts of the rtc stop and clock output block
package rtcs_pkg;
	////////////////////////////////////////////////////////////////////////////////
	// clocking
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned OSC_HZ = 32768;
	localparam int unsigned HUND_HZ = 100;
	// phase step giving two oscillator half-period events per oscillator cycle
	localparam logic [31:0] NCO_INC = 32'(((64'(2 * OSC_HZ)) << 32) / 64'(CLK_HZ));
	localparam int DIV_W = 15;
	localparam logic [15:0] HUND_STEP = 16'(HUND_HZ);
	localparam int unsigned ELAPSED_HOUR_MAX = 999_999;
	////////////////////////////////////////////////////////////////////////////////
	// register map, byte addresses
	localparam int ADDR_W = 8;
	localparam logic [7:0] FUNC_ADDR = 8'h28;
	localparam logic [7:0] CTRL_ADDR = 8'h2c;
	localparam logic [7:0] STAT_ADDR = 8'h30;
	localparam logic [7:0] FUNC_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	////////////////////////////////////////////////////////////////////////////////
	// field codes
	localparam logic [2:0] FREQ_SEL_OSC = 3'h0;
	localparam logic [2:0] FREQ_SEL_1HZ = 3'h6;
	localparam logic [2:0] FREQ_SEL_OFF = 3'h7;
	localparam int DIV_1HZ_BIT = 14;
	localparam logic [1:0] EVT_MODE_CLK = 2'h1;
	localparam logic [1:0] EVT_MODE_INPUT = 2'h3;
	localparam logic [1:0] IRQ_MODE_CLK = 2'h0;
	localparam logic [1:0] IRQ_MODE_BAT = 2'h1;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic hundredths_enable;
		logic [1:0] periodic_sel;
		logic time_count_mode_sel;
		logic stop_source_sel;
		logic [2:0] clkout_freq_sel;
	} rtcs_func_t;

	typedef struct packed {
		logic [1:0] irq_a_pin_mode;
		logic event_pin_polarity;
		logic [1:0] event_pin_mode;
		logic clkout_invert;
		logic clkout_pin_disable;
		logic stop;
	} rtcs_ctrl_t;
endpackage

// File: logic/rtcs_osc_div.sv
// oscillator rate generator and binary prescaler
`timescale 1ns/1ps
module rtcs_osc_div import rtcs_pkg::*; #(
	parameter int W = DIV_W
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// oscillator and prescaler state
	output logic osc_out,
	output logic osc_rise_out,
	output logic [W-1:0] div_out,
	output logic hund_tick_out,
	output logic sec_tick_out
);
	logic [31:0] phase_reg, phase_next;
	logic osc_reg, osc_next;
	logic rise_reg, rise_next;
	logic [W-1:0] div_reg, div_next;
	logic [14:0] hacc_reg, hacc_next;
	logic hund_reg, hund_next;
	logic sec_reg, sec_next;
	logic [32:0] psum;
	logic [15:0] hsum;

	always_comb begin
		psum = {1'b0, phase_reg} + {1'b0, NCO_INC};
		phase_next = psum[31:0];
		osc_next = osc_reg ^ psum[32];
		rise_next = psum[32] & ~osc_reg;
		div_next = div_reg;
		hacc_next = hacc_reg;
		hund_next = 1'b0;
		sec_next = 1'b0;
		hsum = {1'b0, hacc_reg} + HUND_STEP;
		if (rise_next) begin
			// plain binary division keeps every divided output at half duty
			div_next = div_reg + 1'b1;
			hacc_next = hsum[14:0];
			hund_next = hsum[15];
			sec_next = &div_reg;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			phase_reg <= '0;
			osc_reg <= 1'b0;
			rise_reg <= 1'b0;
			div_reg <= '0;
			hacc_reg <= '0;
			hund_reg <= 1'b0;
			sec_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			osc_reg <= osc_next;
			rise_reg <= rise_next;
			div_reg <= div_next;
			hacc_reg <= hacc_next;
			hund_reg <= hund_next;
			sec_reg <= sec_next;
		end
	end

	assign osc_out = osc_reg;
	assign osc_rise_out = rise_reg;
	assign div_out = div_reg;
	assign hund_tick_out = hund_reg;
	assign sec_tick_out = sec_reg;

	a_div_rise_step: assert property (@(posedge clk_in) disable iff (rst_in)
		rise_reg |-> div_reg == $past(div_reg) + 1'b1)
		else $error("prescaler did not step on oscillator rise");
endmodule // rtcs_osc_div

// File: testbench/rtcs_clk_meter.sv
// clock sink model measuring period and high time of a clock pin
`timescale 1ns/1ps
module rtcs_clk_meter (
	// clock
	input wire logic clk_in,
	// observed pin
	input wire logic sig_in,
	// period and high time in clock cycles, and count of rises
	output logic [31:0] period_out,
	output logic [31:0] high_out,
	output logic [31:0] rises_out
);
	logic [31:0] per_cnt;
	logic [31:0] hi_cnt;
	logic sig_q;
	initial begin
		per_cnt = 32'h0;
		hi_cnt = 32'h0;
		sig_q = 1'b0;
		period_out = 32'h0;
		high_out = 32'h0;
		rises_out = 32'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// rise to rise counting
	always @(posedge clk_in) begin
		sig_q <= sig_in;
		if (sig_in === 1'b1 && sig_q === 1'b0) begin
			period_out <= per_cnt;
			high_out <= hi_cnt;
			rises_out <= rises_out + 32'h1;
			per_cnt <= 32'h1;
			hi_cnt <= 32'h1;
		end else begin
			per_cnt <= per_cnt + 32'h1;
			hi_cnt <= hi_cnt + {31'h0, sig_in === 1'b1};
		end
	end
endmodule // rtcs_clk_meter

// File: testbench/rtcs_top_tb_top.sv
// self-checking bench for the stop control and clock output block
`timescale 1ns/1ps
module rtcs_top_tb_top import rtcs_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [2:0] hsize = 3'h0;
	logic evt_drv = 1'b0;
	logic batt = 1'b0;
	logic [31:0] hrdata;
	logic hready, hresp, clkout, evt_out, evt_oe_n, irq_out, irq_oe_n, run, mode, ht, st;
	logic [31:0] per0, hi0, ris0, per1, hi1, ris1, rd;
	logic [4:0] tbl [6] = '{5'b00101, 5'b10100, 5'b10001, 5'b11000, 5'b11101, 5'b11110};
	int num_errors = 0;
	int num_checks = 0;
	int c_hi, i_lo, e_hi;
	always #4 clk = ~clk;
	rtcs_top rtcs_top_i (.CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
		.HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
		.HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
		.EVENT_PIN_IN(evt_oe_n ? evt_drv : evt_out), .ON_BATTERY_IN(batt),
		.CLKOUT_OUT(clkout), .EVENT_PIN_OUT(evt_out), .EVENT_PIN_OE_N_OUT(evt_oe_n),
		.IRQ_A_PIN_OUT(irq_out), .IRQ_A_PIN_OE_N_OUT(irq_oe_n), .COUNT_RUN_OUT(run),
		.TIME_COUNT_MODE_OUT(mode), .HUNDREDTH_TICK_OUT(ht), .SECOND_TICK_OUT(st));
	rtcs_clk_meter rtcs_clk_meter_i (.clk_in(clk), .sig_in(clkout), .period_out(per0),
		.high_out(hi0), .rises_out(ris0));
	rtcs_clk_meter rtcs_clk_meter_evt_i (.clk_in(clk), .sig_in(evt_out), .period_out(per1),
		.high_out(hi1), .rises_out(ris1));
	////////////////////////////////////////////////////////////////////////////////
	// tasks
	task automatic test_done();
		if (num_errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp,
		input logic [31:0] tol);
		num_checks++;
		if ((^seen) === 1'bx || seen + tol < exp || seen > exp + tol) begin
			num_errors++;
			$display("wrong value %s expected %0d seen %0d", nm, exp, seen);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic meas(input logic sel, input logic [31:0] ep, input logic [31:0] eh);
		logic [31:0] r;
		@(negedge clk);
		r = sel ? ris1 : ris0;
		while ((sel ? ris1 : ris0) - r < 32'h3) @(negedge clk);
		chk("period", sel ? per1 : per0, ep, 32'h2);
		if (eh != 32'h0) chk("high time", sel ? hi1 : hi0, eh, 32'h2);
	endtask
	task automatic watch();
		c_hi = 0;
		i_lo = 0;
		e_hi = 0;
		repeat (4) @(negedge clk);
		repeat (4000) begin
			@(negedge clk);
			c_hi += int'(clkout === 1'b1);
			i_lo += int'(irq_oe_n === 1'b0);
			e_hi += int'(evt_oe_n === 1'b0 && evt_out === 1'b1);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// tests
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		test_done();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		ahb(1'b0, FUNC_ADDR, 32'h0);
		chk("function reset", rd, {24'h0, FUNC_RST}, 32'h0);
		ahb(1'b0, 8'h40, 32'h0);
		chk("unmapped read", rd, 32'h0, 32'h0);
		chk("mode", mode, 32'h0, 32'h0);
		chk("idle outputs", {28'h0, hresp, irq_out, ht, st}, 32'h0, 32'h0);
		meas(1'b0, CLK_HZ / OSC_HZ, 32'h0);
		watch();
		chk("irq clock", i_lo != 0, 32'h1, 32'h0);
		ahb(1'b1, CTRL_ADDR, 32'h08);
		ahb(1'b1, FUNC_ADDR, 32'h91);
		ahb(1'b0, FUNC_ADDR, 32'h0);
		chk("function", rd, 32'h91, 32'h0);
		chk("mode", mode, 32'h1, 32'h0);
		meas(1'b0, CLK_HZ / (OSC_HZ / 2), CLK_HZ / OSC_HZ);
		chk("event period", per1, CLK_HZ / (OSC_HZ / 2), 32'h2);
		chk("event high time", hi1, CLK_HZ / OSC_HZ, 32'h2);
		chk("event drive", evt_oe_n, 32'h0, 32'h0);
		ahb(1'b1, FUNC_ADDR, 32'h01);
		repeat (4) @(posedge clk);
		chk("mode", mode, 32'h0, 32'h0);
		batt <= 1'b1;
		watch();
		chk("irq on battery", i_lo, 32'h0, 32'h0);
		@(posedge clk);
		batt <= 1'b0;
		while (clkout !== 1'b0) @(posedge clk);
		while (clkout !== 1'b1) @(posedge clk);
		ahb(1'b1, CTRL_ADDR, 32'h0c);
		repeat (4) @(posedge clk);
		chk("inverted clock", clkout, 32'h0, 32'h0);
		ahb(1'b1, FUNC_ADDR, {24'h0, 5'h0, FREQ_SEL_OFF});
		watch();
		chk("static clock", c_hi, 32'h0, 32'h0);
		chk("static event pin", e_hi, 32'h0, 32'h0);
		chk("irq released", i_lo, 32'h0, 32'h0);
		ahb(1'b1, FUNC_ADDR, 32'h0);
		ahb(1'b1, CTRL_ADDR, 32'h02);
		watch();
		chk("disabled clock", c_hi, 32'h0, 32'h0);
		ahb(1'b1, CTRL_ADDR, 32'h19);
		repeat (6) @(posedge clk);
		chk("run", run, 32'h0, 32'h0);
		for (int k = 0; k < 6; k++) begin
			ahb(1'b1, FUNC_ADDR, {28'h0, tbl[k][4], 3'h0});
			ahb(1'b1, CTRL_ADDR, {26'h0, tbl[k][3], 4'b1100, tbl[k][1]});
			evt_drv <= tbl[k][2];
			repeat (6) @(posedge clk);
			chk("run", run, {31'h0, tbl[k][0]}, 32'h0);
			ahb(1'b0, STAT_ADDR, 32'h0);
			chk("status", {29'h0, rd[2:0]},
				{29'h0, tbl[k][2], tbl[k][4] & (tbl[k][2] ^ tbl[k][3]), tbl[k][0]}, 32'h0);
		end
		test_done();
	end
endmodule // rtcs_top_tb_top
